/* File: cmfgc_params.svh */
`ifndef CMFGC_PARAMS_SVH
`define CMFGC_PARAMS_SVH
// ****************************************
// Address map
// ****************************************
`define CMFGC_CTRL_BASE   10'h000
`define CMFGC_STATE_BASE  10'h200
// ****************************************
// Control low word fields
// ****************************************
`define CMFGC_FIFO_STAGE_COUNT_LSB   0
`define CMFGC_GDFS_BIT    8
`define CMFGC_SOURCE_REMOTE_REQUEST_ON_BIT   9
`define CMFGC_IDC_BIT     10
`define CMFGC_LENGTH_CODE_COPY_ENABLE_BIT    11
`define CMFGC_FD_BIT      13
`define CMFGC_SDT_BIT     14
`define CMFGC_STT_BIT     15
`define CMFGC_LO_RW_MASK  16'hEF1F
// ****************************************
// Control high word and state word fields
// ****************************************
`define CMFGC_PTR_LSB     0
`define CMFGC_MODE_LSB    8
`define CMFGC_MV_LSB      0
`define CMFGC_TRANSMIT_REQUEST_BIT    2
`define CMFGC_DIR_BIT     3
// ****************************************
// Codes and reset values
// ****************************************
`define CMFGC_MODE_STD    3'h0
`define CMFGC_MODE_BASE   3'h2
`define CMFGC_MODE_SLAVE  3'h3
`define CMFGC_MODE_GW     3'h4
`define CMFGC_MODE_SHGW   3'h5
`define CMFGC_MV_RESET    2'h1
`define CMFGC_MV_SET      2'h2
`define CMFGC_FS_1        5'h00
`define CMFGC_FS_2        5'h03
`define CMFGC_FS_4        5'h07
`define CMFGC_FS_8        5'h0F
`define CMFGC_FS_16       5'h1F
`define CMFGC_LO_RESET    16'h0000
`define CMFGC_PTR_RESET   5'h00
`define CMFGC_MODE_RESET  3'h0
`endif

/* File: cmfgc_pkg.sv */
package cmfgc_pkg;
  // Kind of event reported by a CAN node
  typedef enum logic [1:0] {
    CMFGC_EV_RX_OK,
    CMFGC_EV_TX_OK,
    CMFGC_EV_TX_START
  } cmfgc_ev_kind_t;

  // One-cycle event from a node
  typedef struct packed {
    logic           valid;
    cmfgc_ev_kind_t kind;
    logic [4:0]     obj;
    logic           remote;
  } cmfgc_event_t;

  // Gateway transfer command to the object store
  typedef struct packed {
    logic       valid;
    logic [4:0] src;
    logic [4:0] dst;
    logic       copy_id;
    logic       copy_dlc;
    logic       remote;
  } cmfgc_gw_cmd_t;
endpackage

/* File: cmfgc_top.sv */
// What this block does
// - Gateway copies identifier when copy bit set
// - Gateway copies length code on data frames when its copy bit is set
// - Direction 0: advance pointer on reception, or on a gateway transfer into the FIFO
// - Direction 1: advance pointer on transmission, or on a gateway transfer into the FIFO
// - Direction bit read from base object only
// - Single transfer clears message valid after success
// - Remote frames never clear message valid
// - Single try clears transmit request at start
// - Base pointer names next addressed object
// - Gateway pointer names destination object
// - Destination with remote enable forwards remote back
// - Pointer write resets FIFO position
// - Mode field selects object behaviour
// - Size field combines 1 to 16 objects
// - Transmit pointer applies on message valid set
//
// Our own choices: the register addresses and the APB interface to the registers.
`include "cmfgc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cmfgc_top (
  input  wire logic                   CORE_CLK_I,
  input  wire logic                   NRST_I,
  input  wire logic                   PSEL_I,
  input  wire logic                   PENABLE_I,
  input  wire logic                   PWRITE_I,
  input  wire logic [9:0]             PADDR_I,
  input  wire logic [31:0]            PWDATA_I,
  output logic      [31:0]            PRDATA_O,
  output logic                        PREADY_O,
  output logic                        PSLVERR_O,
  input  wire cmfgc_pkg::cmfgc_event_t EVENT_I,
  output cmfgc_pkg::cmfgc_gw_cmd_t    GW_CMD_O,
  output logic      [31:0]            TRANSMIT_REQUEST_O,
  output logic      [31:0]            OBJ_VALID_O
);

  // ****************************************
  // Object storage
  // ****************************************
  logic [15:0] lo_q   [32];
  logic [4:0]  ptr_q  [32];
  logic [4:0]  pend_q [32];
  logic [2:0]  mode_q [32];
  logic [1:0]  mv_q   [32];
  logic        transmit_request_q [32];
  logic        dir_q  [32];
  logic [31:0] prdata_q;
  cmfgc_pkg::cmfgc_gw_cmd_t gw_q;

  // ****************************************
  // APB decode
  // ****************************************
  wire        setup    = PSEL_I & ~PENABLE_I;
  wire        access   = PSEL_I & PENABLE_I;
  wire        in_ctrl  = (PADDR_I[9:8] == 2'h0);
  wire        in_state = (PADDR_I[9:7] == 3'h4);
  wire        mapped   = (in_ctrl | in_state) & (PADDR_I[1:0] == 2'h0);
  wire [4:0]  c_obj    = PADDR_I[7:3];
  wire        c_hi     = PADDR_I[2];
  wire [4:0]  s_obj    = PADDR_I[6:2];
  wire        wr_acc   = access & PWRITE_I & mapped;
  wire        wr_lo    = wr_acc & in_ctrl & ~c_hi;
  wire        wr_hi    = wr_acc & in_ctrl & c_hi;
  wire        wr_st    = wr_acc & in_state;
  wire [1:0]  wr_mv    = PWDATA_I[`CMFGC_MV_LSB +: 2];

  // Read value; reserved bits return zero
  wire [15:0] rd_lo    = lo_q[c_obj];
  wire [15:0] rd_hi    = {5'h00, mode_q[c_obj], 3'h0, ptr_q[c_obj]};
  wire [15:0] rd_st    = {12'h000, dir_q[s_obj], transmit_request_q[s_obj], mv_q[s_obj]};
  wire [15:0] rd_sel   = in_state ? rd_st : (c_hi ? rd_hi : rd_lo);
  wire [31:0] rd_val   = mapped ? {16'h0000, rd_sel} : 32'h0000_0000;

  // ****************************************
  // Event decode
  // ****************************************
  wire        ev_rx    = EVENT_I.valid & (EVENT_I.kind == cmfgc_pkg::CMFGC_EV_RX_OK);
  wire        ev_tx    = EVENT_I.valid & (EVENT_I.kind == cmfgc_pkg::CMFGC_EV_TX_OK);
  wire        ev_start = EVENT_I.valid & (EVENT_I.kind == cmfgc_pkg::CMFGC_EV_TX_START);
  wire [4:0]  k        = EVENT_I.obj;
  wire [2:0]  k_mode   = mode_q[k];
  wire [15:0] k_lo     = lo_q[k];
  wire        k_in_fifo = (k_mode == `CMFGC_MODE_BASE) | (k_mode == `CMFGC_MODE_SLAVE);

  // Clear message valid on data transfers only
  wire        sdt_clr  = (ev_rx | ev_tx) & ~EVENT_I.remote
                       & k_lo[`CMFGC_SDT_BIT];
  // Drop the request as soon as sending begins
  wire        stt_clr  = ev_start & k_lo[`CMFGC_STT_BIT];

  // Normal gateway source receiving a frame
  wire        gw_hit   = ev_rx & (k_mode == `CMFGC_MODE_GW);
  wire [4:0]  gw_dst   = ptr_q[k];
  wire        gw_fifo  = gw_hit & (mode_q[gw_dst] == `CMFGC_MODE_BASE);
  wire [4:0]  gw_eff   = gw_fifo ? ptr_q[gw_dst] : gw_dst;

  // FIFO element: base is itself or its pointer target
  wire [4:0]  f_base   = gw_fifo ? gw_dst
                       : ((k_mode == `CMFGC_MODE_BASE) ? k : ptr_q[k]);
  wire [4:0]  f_cur    = gw_fifo ? ptr_q[gw_dst] : k;
  wire [15:0] b_lo     = lo_q[f_base];
  wire [4:0]  b_fs     = b_lo[`CMFGC_FIFO_STAGE_COUNT_LSB +: 5];
  wire        b_fd     = b_lo[`CMFGC_FD_BIT];
  wire        fs_ok    = (b_fs == `CMFGC_FS_2) | (b_fs == `CMFGC_FS_4)
                       | (b_fs == `CMFGC_FS_8) | (b_fs == `CMFGC_FS_16);
  wire        b_is_base = (mode_q[f_base] == `CMFGC_MODE_BASE);
  wire        dir_ok   = b_fd ? ev_tx : ev_rx;
  wire        addr_ok  = (ptr_q[f_base] == f_cur);
  wire        adv      = (gw_fifo | (k_in_fifo & dir_ok & addr_ok)) & b_is_base & fs_ok;
  wire [4:0]  cur_inc  = f_cur + 5'h01;
  // Size code is twice the stage count less one, so the index mask is half of it
  wire [4:0]  b_mask   = {1'b0, b_fs[4:1]};
  // Wrap inside the aligned group so the pointer never leaves the FIFO
  wire [4:0]  adv_next = (f_cur & ~b_mask) | (cur_inc & b_mask);

  // Transmit request sets caused by gateway traffic and received remote frames
  wire        gw_send  = gw_hit & ~EVENT_I.remote & k_lo[`CMFGC_GDFS_BIT];
  wire        rem_dest = ev_rx & EVENT_I.remote & dir_q[k] & (k_mode == `CMFGC_MODE_STD);
  wire        rem_back = rem_dest & k_lo[`CMFGC_SOURCE_REMOTE_REQUEST_ON_BIT];
  wire        rem_self = rem_dest & ~k_lo[`CMFGC_SOURCE_REMOTE_REQUEST_ON_BIT];
  wire        set_any  = gw_send | rem_back | rem_self;
  wire [4:0]  set_obj  = gw_send ? gw_eff : (rem_back ? ptr_q[k] : k);

  // ****************************************
  // Per-object registers
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_obj
      wire [4:0] me   = 5'(gi);
      wire       sw_l = wr_lo & (c_obj == me);
      wire       sw_h = wr_hi & (c_obj == me);
      wire       sw_s = wr_st & (s_obj == me);
      wire       hw_a = adv & (f_base == me);
      wire       hw_m = sdt_clr & (k == me);
      wire       hw_t = stt_clr & (k == me);
      wire       hw_s = set_any & (set_obj == me);

      // Control words and pointer
      always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
          lo_q[gi]   <= `CMFGC_LO_RESET;
          mode_q[gi] <= `CMFGC_MODE_RESET;
          ptr_q[gi]  <= `CMFGC_PTR_RESET;
          pend_q[gi] <= `CMFGC_PTR_RESET;
        end else begin
          if (sw_l) begin
            lo_q[gi] <= PWDATA_I[15:0] & `CMFGC_LO_RW_MASK;
          end
          if (sw_h) begin
            mode_q[gi] <= PWDATA_I[`CMFGC_MODE_LSB +: 3];
          end
          // Transmit objects hold the new pointer until activation
          if (sw_h & dir_q[gi]) begin
            pend_q[gi] <= PWDATA_I[`CMFGC_PTR_LSB +: 5];
          end
          if (sw_h & ~dir_q[gi]) begin
            ptr_q[gi] <= PWDATA_I[`CMFGC_PTR_LSB +: 5];
          end else if (sw_s & dir_q[gi] & (wr_mv == `CMFGC_MV_SET)) begin
            ptr_q[gi] <= pend_q[gi];
          end else if (hw_a) begin
            ptr_q[gi] <= adv_next;
          end
        end
      end

      // Message valid, request and direction; sets win over clears
      always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
          mv_q[gi]   <= `CMFGC_MV_RESET;
          transmit_request_q[gi] <= 1'b0;
          dir_q[gi]  <= 1'b0;
        end else begin
          if (hw_m) begin
            mv_q[gi] <= `CMFGC_MV_RESET;
          end
          if (sw_s & ((wr_mv == `CMFGC_MV_SET) | (wr_mv == `CMFGC_MV_RESET))) begin
            mv_q[gi] <= wr_mv;
          end
          if (hw_t) begin
            transmit_request_q[gi] <= 1'b0;
          end
          if (sw_s) begin
            transmit_request_q[gi] <= PWDATA_I[`CMFGC_TRANSMIT_REQUEST_BIT];
            dir_q[gi]  <= PWDATA_I[`CMFGC_DIR_BIT];
          end
          if (hw_s) begin
            transmit_request_q[gi] <= 1'b1;
          end
        end
      end

      assign TRANSMIT_REQUEST_O[gi]      = transmit_request_q[gi];
      assign OBJ_VALID_O[gi] = (mv_q[gi] == `CMFGC_MV_SET);
    end
  endgenerate

  // ****************************************
  // Gateway command and bus outputs
  // ****************************************
  // Command is a one-cycle pulse one edge after the event
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      gw_q <= '0;
    end else begin
      gw_q.valid    <= gw_hit;
      gw_q.src      <= k;
      gw_q.dst      <= gw_eff;
      gw_q.copy_id  <= k_lo[`CMFGC_IDC_BIT];
      gw_q.copy_dlc <= k_lo[`CMFGC_LENGTH_CODE_COPY_ENABLE_BIT] & ~EVENT_I.remote;
      gw_q.remote   <= EVENT_I.remote;
    end
  end

  // Read data captured in setup so the access phase needs no wait
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= rd_val;
    end
  end

  assign GW_CMD_O  = gw_q;
  assign PRDATA_O  = prdata_q;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = access & ~mapped;

endmodule
`default_nettype wire

/* File: cmfgc_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module cmfgc_sva (
  input wire logic                     CORE_CLK_I,
  input wire logic                     NRST_I,
  input wire logic                     PSEL_I,
  input wire logic                     PENABLE_I,
  input wire logic                     PWRITE_I,
  input wire cmfgc_pkg::cmfgc_event_t  EVENT_I,
  input wire cmfgc_pkg::cmfgc_gw_cmd_t GW_CMD_O,
  input wire logic [31:0]              TRANSMIT_REQUEST_O,
  input wire logic [31:0]              OBJ_VALID_O
);
  // ****
  // Causes and checks
  // ****
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);
  // Only a bus write or a node event may move object state
  wire wr = PSEL_I & PENABLE_I & PWRITE_I;
  wire rx = EVENT_I.valid & (EVENT_I.kind == cmfgc_pkg::CMFGC_EV_RX_OK);
  wire tx = EVENT_I.valid & (EVENT_I.kind != cmfgc_pkg::CMFGC_EV_RX_OK);
  wire ok = EVENT_I.valid & ~EVENT_I.remote & (EVENT_I.kind != cmfgc_pkg::CMFGC_EV_TX_START);
  sequence s_rx_gw;
    rx ##1 GW_CMD_O.valid;
  endsequence
  AST_GW_CAUSE: assert property (GW_CMD_O.valid |-> $past(rx))
    else $error("gateway command without reception");
  AST_GW_SRC: assert property (s_rx_gw |-> GW_CMD_O.src == $past(EVENT_I.obj))
    else $error("gateway source wrong");
  AST_GW_REMOTE: assert property (s_rx_gw |-> GW_CMD_O.remote == $past(EVENT_I.remote))
    else $error("gateway frame kind wrong");
  AST_DLC_REMOTE: assert property (GW_CMD_O.valid && GW_CMD_O.remote |-> !GW_CMD_O.copy_dlc)
    else $error("length copied on remote frame");
  AST_MV_FALL: assert property (|($past(OBJ_VALID_O) & ~OBJ_VALID_O) |-> $past(wr) || $past(ok))
    else $error("message valid cleared without cause");
  AST_MV_RISE: assert property (|(~$past(OBJ_VALID_O) & OBJ_VALID_O) |-> $past(wr))
    else $error("message valid set without write");
  AST_TRANSMIT_REQUEST_FALL: assert property (|($past(TRANSMIT_REQUEST_O) & ~TRANSMIT_REQUEST_O) |-> $past(wr) || $past(tx))
    else $error("transmit request dropped without cause");
  AST_TRANSMIT_REQUEST_RISE: assert property (|(~$past(TRANSMIT_REQUEST_O) & TRANSMIT_REQUEST_O) |-> $past(wr) || $past(rx))
    else $error("transmit request raised without cause");
endmodule
bind cmfgc_top cmfgc_sva u_sva (.CORE_CLK_I, .NRST_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
  .EVENT_I, .GW_CMD_O, .TRANSMIT_REQUEST_O, .OBJ_VALID_O);
`default_nettype wire

/* File: cmfgc_node.sv */
`timescale 1ns/1ps
`default_nettype none
module cmfgc_node (
  input wire logic                    CORE_CLK_I,
  output var cmfgc_pkg::cmfgc_event_t EVENT_O
);
  // ****
  // Node event source
  // ****
  initial EVENT_O = '0;
  // One-cycle pulse; idle object and remote fields inverted, kind kept, so stale values never match
  task automatic send(input cmfgc_pkg::cmfgc_ev_kind_t k, input logic [4:0] o, input logic r);
    @(posedge CORE_CLK_I);
    EVENT_O <= '{1'h1, k, o, r};
    @(posedge CORE_CLK_I);
    EVENT_O <= '{1'h0, k, ~o, ~r};
    #1;
  endtask
endmodule
`default_nettype wire

/* File: cmfgc_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module cmfgc_top_bench;
  // ****
  // Bench
  // ****
  logic        CORE_CLK_I, NRST_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O, er;
  logic [9:0]  PADDR_I;
  logic [31:0] PWDATA_I, PRDATA_O, TRANSMIT_REQUEST_O, OBJ_VALID_O, rd;
  int          n_mismatch, samples_checked;
  cmfgc_pkg::cmfgc_event_t  EVENT_I;
  cmfgc_pkg::cmfgc_gw_cmd_t GW_CMD_O;
  localparam cmfgc_pkg::cmfgc_ev_kind_t RX = cmfgc_pkg::CMFGC_EV_RX_OK;
  localparam cmfgc_pkg::cmfgc_ev_kind_t TX = cmfgc_pkg::CMFGC_EV_TX_OK;
  localparam cmfgc_pkg::cmfgc_ev_kind_t ST = cmfgc_pkg::CMFGC_EV_TX_START;
  cmfgc_top uut (.CORE_CLK_I, .NRST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
    .PRDATA_O, .PREADY_O, .PSLVERR_O, .EVENT_I, .GW_CMD_O, .TRANSMIT_REQUEST_O, .OBJ_VALID_O);
  cmfgc_node u_node (.CORE_CLK_I, .EVENT_O(EVENT_I));
  initial begin
    CORE_CLK_I = 1'h0;
    forever #5 CORE_CLK_I = ~CORE_CLK_I;
  end
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // Setup then access; wait for ready is bounded so a hang ends the run
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int i;
    @(posedge CORE_CLK_I);
    PSEL_I <= 1'h1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge CORE_CLK_I);
    PENABLE_I <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge CORE_CLK_I);
      if (PREADY_O === 1'h1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      results();
    end
    rd = PRDATA_O;
    er = PSLVERR_O;
    PSEL_I <= 1'h0;
    PENABLE_I <= 1'h0;
    #1;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rc(input logic [9:0] a, input logic [31:0] e, input string m);
    apb(1'h0, a, 32'h0);
    chk(rd, e, m);
  endtask
  task automatic t_regs();
    rc(10'h000, 32'h0, "low reset");
    rc(10'h200, 32'h1, "state reset");
    wr(10'h000, 32'hFFFFFFFF);
    rc(10'h000, 32'hEF1F, "low mask");
    wr(10'h000, 32'h0);
    apb(1'h0, 10'h300, 32'h0);
    chk(er, 32'h1, "unmapped error");
    $display("regs done");
  endtask
  task automatic t_gw();
    wr(10'h014, 32'h0405);
    wr(10'h010, 32'h0D00);
    u_node.send(RX, 5'h02, 1'h0);
    chk(GW_CMD_O, {1'h1, 5'h02, 5'h05, 3'h6}, "gw data");
    chk(TRANSMIT_REQUEST_O[5], 32'h1, "gw send");
    u_node.send(RX, 5'h02, 1'h1);
    chk(GW_CMD_O, {1'h1, 5'h02, 5'h05, 3'h5}, "gw remote");
    wr(10'h010, 32'h0100);
    u_node.send(RX, 5'h02, 1'h0);
    chk(GW_CMD_O, {1'h1, 5'h02, 5'h05, 3'h0}, "gw no copy");
    // Standard transmit object with remote enable points back to object 2
    wr(10'h064, 32'h0002);
    wr(10'h060, 32'h0200);
    wr(10'h230, 32'h8);
    u_node.send(RX, 5'h0C, 1'h1);
    chk(TRANSMIT_REQUEST_O[2], 32'h1, "remote back");
    chk(TRANSMIT_REQUEST_O[12], 32'h0, "remote not own");
    // Transmit object pointer waits for message valid set
    wr(10'h234, 32'h8);
    wr(10'h06C, 32'h0007);
    rc(10'h06C, 32'h0000, "pointer pending");
    wr(10'h234, 32'hA);
    rc(10'h06C, 32'h0007, "pointer applied");
    $display("gateway done");
  endtask
  // Single transfer stays off in every FIFO element; base pointer is rewritten once to check restart
  task automatic t_fifo();
    wr(10'h024, 32'h0204);
    wr(10'h020, 32'h0003);
    wr(10'h02C, 32'h0304);
    u_node.send(RX, 5'h04, 1'h0);
    rc(10'h024, 32'h0205, "rx advance");
    u_node.send(TX, 5'h05, 1'h0);
    rc(10'h024, 32'h0205, "tx no advance");
    u_node.send(RX, 5'h05, 1'h0);
    rc(10'h024, 32'h0204, "wrap");
    wr(10'h020, 32'h2003);
    u_node.send(RX, 5'h04, 1'h0);
    rc(10'h024, 32'h0204, "rx no advance");
    u_node.send(TX, 5'h04, 1'h0);
    rc(10'h024, 32'h0205, "tx advance");
    wr(10'h024, 32'h0204);
    u_node.send(TX, 5'h04, 1'h0);
    rc(10'h024, 32'h0205, "restart");
    $display("fifo done");
  endtask
  task automatic t_single();
    wr(10'h040, 32'h4000);
    wr(10'h220, 32'h2);
    u_node.send(RX, 5'h08, 1'h1);
    chk(OBJ_VALID_O[8], 32'h1, "remote kept");
    u_node.send(RX, 5'h08, 1'h0);
    chk(OBJ_VALID_O[8], 32'h0, "single clear");
    wr(10'h224, 32'h2);
    u_node.send(RX, 5'h09, 1'h0);
    chk(OBJ_VALID_O[9], 32'h1, "valid kept");
    wr(10'h050, 32'h8000);
    wr(10'h228, 32'h6);
    wr(10'h22C, 32'h6);
    u_node.send(ST, 5'h0A, 1'h0);
    chk(TRANSMIT_REQUEST_O[11:10], 32'h2, "single try");
    $display("single done");
  endtask
  initial begin
    NRST_I = 1'h0;
    PSEL_I = 1'h0;
    PENABLE_I = 1'h0;
    PWRITE_I = 1'h0;
    PADDR_I = 10'h0;
    PWDATA_I = 32'h0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (3) @(posedge CORE_CLK_I);
    NRST_I <= 1'h1;
    t_regs();
    t_gw();
    t_fifo();
    t_single();
    results();
  end
endmodule
`default_nettype wire
